/* logic/hecl_loader.v */
/*
 * Hub configuration loader: reads the extended image from an SPI EEPROM
 * after reset, holds the decoded fields and offers them over AHB-Lite.
 * Assumes a single AHB-Lite master with word transfers and a mode 0 EEPROM.
 */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
// Summary of operation
// R01: Byte 0 must be 0xd4 before any extended field is used.
// R02: Vendor ID is byte 1 low, byte 2 high.
// R03: Product ID is byte 3 low, byte 4 high.
// R04: Device release high byte is byte 6; byte 5 unused.
// R05: Byte 7 nibbles give enabled/disabled port filter ms, default 0x88.
// R06: Full speed maximum power is byte 8, default 0x28.
// R07: High speed maximum power is byte 9, default 0x57.
// R08: Bytes 10 and 11 are written zero by the programmer; ignored here.
// R09: Full speed bus powered controller current is byte 12, default 0x50.
// R10: High speed bus powered controller current is byte 13, default 0xae.
// R11: Full speed self powered controller current is byte 14, default 0x50.
// R12: High speed self powered controller current is byte 15, default 0x64.
// R13: Reported controller current follows live speed and powering state.
// R14: Port power good delay is byte 16, default 0x32.
// R15: Byte 19 equal 0x42 blocks every later EEPROM write.
// R16: Language count zero or above 31 disables string support.
// R17: String table entries are two bytes, low first, one per language. The code reads no string table; the load stops after image byte 23.
`timescale 1ns/100ps
`include "hecl_regs.vh"
module hecl_loader #(
    parameter IMG_AW = `HECL_IMG_AW
) (
    input wire hclk, // Core clock, 200 MHz.
    input wire hresetn, // Asynchronous reset, active low.
    input wire hsel, // Slave select.
    input wire [7:0] haddr, // Byte address.
    input wire [1:0] htrans, // Transfer type.
    input wire hwrite, // Write when high.
    input wire [2:0] hsize, // Transfer size.
    input wire [31:0] hwdata, // Write data.
    input wire hready, // Bus ready.
    output reg [31:0] hrdata, // Read data.
    output reg hreadyout, // Slave ready.
    output reg hresp, // Always OKAY.
    input wire high_speed, // Upstream link is high speed.
    input wire self_powered, // Hub is self powered.
    input wire spi_miso, // EEPROM serial data in.
    output reg spi_cs_n, // EEPROM chip select, active low.
    output reg spi_sck, // EEPROM serial clock.
    output reg spi_mosi, // EEPROM serial data out.
    output reg cfg_valid, // Extended image accepted.
    output reg [15:0] vendor_id, // Vendor identifier.
    output reg [15:0] product_id, // Product identifier.
    output reg [7:0] device_id_hi, // Device release high byte.
    output reg [3:0] enabled_port_oc_filter_ms, // Filter for enabled ports.
    output reg [3:0] disabled_port_oc_filter_ms, // Filter for disabled ports.
    output reg [7:0] upstream_current_budget, // Reported maximum power.
    output reg [7:0] controller_current_draw, // Reported controller current.
    output reg [7:0] port_power_good_delay, // Power good delay, 2 ms units.
    output reg write_protect, // EEPROM writes refused.
    output reg strings_enabled // String descriptors supported.
);
    localparam S_IDLE = 7'h01;
    localparam S_CMD = 7'h02;
    localparam S_ADR = 7'h04;
    localparam S_DAT = 7'h08;
    localparam S_DEC = 7'h10;
    localparam S_WR = 7'h20;
    localparam S_DONE = 7'h40;

    reg [6:0] st_r;
    reg [1:0] miso_sync_r;
    reg [IMG_AW:0] idx_r;
    reg [1:0] phase_r;
    reg [2:0] wstep_r;
    reg start_r;
    reg [7:0] tx_r;
    reg [7:0] b_sig_r, b_oc_r, b_mpfs_r, b_mphs_r, b_fsb_r, b_hsb_r, b_fss_r, b_hss_r;
    reg [7:0] b_pg_r, b_nl_r, vid_lo_r, vid_hi_r, pid_lo_r, pid_hi_r, did_r;
    reg [7:0] mem_raddr_r;
    reg wr_req_r, wr_refused_r, wr_done_r, load_go_r;
    reg [7:0] wr_addr_r, wr_data_r;
    reg ap_valid_r, ap_write_r;
    reg [7:0] ap_addr_r;
    wire [7:0] rx;
    wire done;
    wire sck_w, mosi_w;
    wire [7:0] mem_rd;
    wire ext_ok = (b_sig_r == `HECL_SIG_EXT); // R01
    wire take = hsel && hready && htrans[1];

    // The EEPROM line crosses from outside; two flops before use.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_sync_r <= 2'b00;
        end else begin
            miso_sync_r <= {miso_sync_r[0], spi_miso};
        end
    end

    hecl_spi_byte u_spi (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start_r),
        .tx(tx_r),
        .miso_s(miso_sync_r[1]),
        .rx_r(rx),
        .done_r(done),
        .sck_r(sck_w),
        .mosi_r(mosi_w)
    );

    // A copy of the raw image for software inspection.
    hecl_image_mem #(.AW(IMG_AW)) u_mem (
        .hclk(hclk),
        .we(done && st_r == S_DAT),
        .waddr(idx_r[IMG_AW-1:0]),
        .wdata(rx),
        .raddr(mem_raddr_r[IMG_AW-1:0]),
        .rdata(mem_rd)
    );

    // Loader sequence: read command, address, then the image bytes in order.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= S_IDLE;
            idx_r <= {(IMG_AW+1){1'b0}};
            phase_r <= 2'b00;
            wstep_r <= 3'h0;
            start_r <= 1'b0;
            tx_r <= 8'h00;
            spi_cs_n <= 1'b1;
            b_sig_r <= 8'h00; b_oc_r <= 8'h00; b_mpfs_r <= 8'h00; b_mphs_r <= 8'h00;
            b_fsb_r <= 8'h00; b_hsb_r <= 8'h00; b_fss_r <= 8'h00; b_hss_r <= 8'h00;
            b_pg_r <= 8'h00; b_nl_r <= 8'h00; vid_lo_r <= 8'h00; vid_hi_r <= 8'h00;
            pid_lo_r <= 8'h00; pid_hi_r <= 8'h00; did_r <= 8'h00;
            write_protect <= 1'b0;
            wr_refused_r <= 1'b0;
            wr_done_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (load_go_r) begin
                        spi_cs_n <= 1'b0;
                        tx_r <= `HECL_CMD_READ;
                        start_r <= 1'b1;
                        phase_r <= 2'b00;
                        st_r <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (done) begin
                        tx_r <= 8'h00;
                        start_r <= 1'b1;
                        st_r <= S_ADR;
                    end
                end
                S_ADR: begin
                    if (done) begin
                        start_r <= 1'b1;
                        phase_r <= phase_r + 2'b01;
                        if (phase_r == 2'b01) begin
                            idx_r <= {(IMG_AW+1){1'b0}};
                            st_r <= S_DAT;
                        end
                    end
                end
                S_DAT: begin
                    if (done) begin
                        case (idx_r[IMG_AW-1:0])
                            `HECL_B_SIG: b_sig_r <= rx; // R01
                            `HECL_B_VID_LO: vid_lo_r <= rx; // R02
                            `HECL_B_VID_HI: vid_hi_r <= rx; // R02
                            `HECL_B_PID_LO: pid_lo_r <= rx; // R03
                            `HECL_B_PID_HI: pid_hi_r <= rx; // R03
                            `HECL_B_DID_HI: did_r <= rx; // R04
                            `HECL_B_OC: b_oc_r <= rx; // R05
                            `HECL_B_MP_FS: b_mpfs_r <= rx; // R06
                            `HECL_B_MP_HS: b_mphs_r <= rx; // R07
                            `HECL_B_HC_FSB: b_fsb_r <= rx; // R09
                            `HECL_B_HC_HSB: b_hsb_r <= rx; // R10
                            `HECL_B_HC_FSS: b_fss_r <= rx; // R11
                            `HECL_B_HC_HSS: b_hss_r <= rx; // R12
                            `HECL_B_PGOOD: b_pg_r <= rx; // R14
                            `HECL_B_WP: write_protect <= (rx == `HECL_WP_KEY); // R15
                            `HECL_B_NLANG: b_nl_r <= rx; // R16
                            default: ; // Bytes 5, 10 and 11 carry nothing.
                        endcase
                        if (idx_r == `HECL_IMG_LEN - 6'h01) begin
                            spi_cs_n <= 1'b1;
                            st_r <= S_DEC;
                        end else begin
                            start_r <= 1'b1;
                        end
                        idx_r <= idx_r + 1'b1;
                    end
                end
                S_DEC: begin
                    // A wrong signature clears write protect as well.
                    if (!ext_ok) begin
                        write_protect <= 1'b0; // R01
                    end
                    st_r <= S_DONE;
                end
                S_DONE: begin
                    wr_done_r <= 1'b0;
                    if (wr_req_r) begin
                        if (write_protect) begin
                            wr_refused_r <= 1'b1; // R15
                            wr_done_r <= 1'b1;
                        end else begin
                            wr_refused_r <= 1'b0;
                            spi_cs_n <= 1'b0;
                            tx_r <= `HECL_CMD_WREN;
                            start_r <= 1'b1;
                            wstep_r <= 3'h0;
                            st_r <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    // Enable latch, deselect, then write command, address, data.
                    if (done || wstep_r == 3'h1) begin
                        wstep_r <= wstep_r + 3'h1;
                        start_r <= 1'b1;
                        case (wstep_r)
                            3'h0: begin spi_cs_n <= 1'b1; start_r <= 1'b0; end
                            3'h1: begin spi_cs_n <= 1'b0; tx_r <= `HECL_CMD_WRITE; end
                            3'h2: tx_r <= 8'h00;
                            3'h3: tx_r <= wr_addr_r;
                            3'h4: tx_r <= wr_data_r;
                            default: begin
                                start_r <= 1'b0;
                                spi_cs_n <= 1'b1;
                                wr_done_r <= 1'b1;
                                st_r <= S_DONE;
                            end
                        endcase
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Decoded outputs: IDs always from the image; the rest image values when the signature matched, else defaults.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_valid <= 1'b0;
            vendor_id <= 16'h0000;
            product_id <= 16'h0000;
            device_id_hi <= 8'h00;
            enabled_port_oc_filter_ms <= 4'h8;
            disabled_port_oc_filter_ms <= 4'h8;
            upstream_current_budget <= `HECL_DEF_MP_FS;
            controller_current_draw <= `HECL_DEF_HC_FSB;
            port_power_good_delay <= `HECL_DEF_PGOOD;
            strings_enabled <= 1'b0;
        end else begin
            cfg_valid <= (st_r == S_DONE || st_r == S_WR) && ext_ok; // R01
            vendor_id <= {vid_hi_r, vid_lo_r}; // R02
            product_id <= {pid_hi_r, pid_lo_r}; // R03
            device_id_hi <= did_r; // R04
            {enabled_port_oc_filter_ms, disabled_port_oc_filter_ms} <=
                ext_ok ? b_oc_r : `HECL_DEF_OC; // R05
            if (high_speed) begin
                upstream_current_budget <= ext_ok ? b_mphs_r : `HECL_DEF_MP_HS; // R07
            end else begin
                upstream_current_budget <= ext_ok ? b_mpfs_r : `HECL_DEF_MP_FS; // R06
            end
            // Re-evaluated every cycle so a speed or supply change shows on the next clock.
            case ({high_speed, self_powered}) // R13
                2'b00: controller_current_draw <= ext_ok ? b_fsb_r : `HECL_DEF_HC_FSB; // R09
                2'b10: controller_current_draw <= ext_ok ? b_hsb_r : `HECL_DEF_HC_HSB; // R10
                2'b01: controller_current_draw <= ext_ok ? b_fss_r : `HECL_DEF_HC_FSS; // R11
                default: controller_current_draw <= ext_ok ? b_hss_r : `HECL_DEF_HC_HSS; // R12
            endcase
            port_power_good_delay <= ext_ok ? b_pg_r : `HECL_DEF_PGOOD; // R14
            strings_enabled <= ext_ok && b_nl_r != 8'h00 && b_nl_r <= `HECL_NLANG_MAX; // R16
        end
    end

    // AHB-Lite slave: zero wait state, registered address phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            load_go_r <= 1'b1;
            wr_req_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            mem_raddr_r <= 8'h00;
        end else begin
            ap_valid_r <= take;
            ap_write_r <= hwrite;
            ap_addr_r <= haddr;
            if (st_r != S_IDLE) begin
                load_go_r <= 1'b0;
            end
            if (wr_done_r) begin
                wr_req_r <= 1'b0;
            end
            if (take && !hwrite) begin
                if (haddr == `HECL_A_CTRL) begin
                    hrdata <= {24'h000000, 5'h00, wr_req_r, write_protect, load_go_r};
                end else if (haddr == `HECL_A_STAT) begin
                    hrdata <= {24'h000000, wr_refused_r, strings_enabled, cfg_valid, st_r[4:0]};
                end else if (haddr == `HECL_A_IDS) begin
                    hrdata <= {product_id, vendor_id};
                end else if (haddr == `HECL_A_DID) begin
                    hrdata <= {16'h0000, mem_rd, device_id_hi};
                end else if (haddr == `HECL_A_POWER) begin
                    hrdata <= {port_power_good_delay, controller_current_draw,
                               upstream_current_budget, enabled_port_oc_filter_ms,
                               disabled_port_oc_filter_ms};
                end else if (haddr == `HECL_A_WRITE) begin
                    hrdata <= {16'h0000, wr_data_r, wr_addr_r};
                end else if (haddr == `HECL_A_STRING) begin
                    hrdata <= {24'h000000, b_nl_r}; // R16
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
            if (ap_valid_r && ap_write_r) begin
                if (ap_addr_r == `HECL_A_CTRL) begin
                    if (hwdata[0] && st_r == S_DONE) begin
                        load_go_r <= 1'b1;
                    end
                    if (hwdata[2]) begin
                        wr_req_r <= 1'b1;
                    end
                end else if (ap_addr_r == `HECL_A_WRITE) begin
                    wr_addr_r <= hwdata[7:0];
                    wr_data_r <= hwdata[15:8];
                    mem_raddr_r <= hwdata[23:16];
                end
            end
        end
    end

    // The load cannot be re-run from S_DONE: S_DONE never returns to idle.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_sck <= 1'b0;
            spi_mosi <= 1'b0;
        end else begin
            spi_sck <= sck_w;
            spi_mosi <= mosi_w;
        end
    end
endmodule

/* logic/hecl_regs.vh */
/*
 * Constants of the hub configuration loader: image offsets, defaults,
 * SPI commands, register offsets and timing.
 * Assumes inclusion by bare name from the loader modules only.
 */
`ifndef HECL_REGS_VH
`define HECL_REGS_VH

// Image layout.
`define HECL_SIG_EXT 8'hd4
`define HECL_IMG_LEN 6'h18
`define HECL_IMG_AW 5
`define HECL_B_SIG 5'h00
`define HECL_B_VID_LO 5'h01
`define HECL_B_VID_HI 5'h02
`define HECL_B_PID_LO 5'h03
`define HECL_B_PID_HI 5'h04
`define HECL_B_DID_HI 5'h06
`define HECL_B_OC 5'h07
`define HECL_B_MP_FS 5'h08
`define HECL_B_MP_HS 5'h09
`define HECL_B_HC_FSB 5'h0c
`define HECL_B_HC_HSB 5'h0d
`define HECL_B_HC_FSS 5'h0e
`define HECL_B_HC_HSS 5'h0f
`define HECL_B_PGOOD 5'h10
`define HECL_B_WP 5'h13
`define HECL_B_NLANG 5'h14
`define HECL_WP_KEY 8'h42
`define HECL_NLANG_MAX 8'h1f

// Defaults used when no extended image is present.
`define HECL_DEF_OC 8'h88
`define HECL_DEF_MP_FS 8'h28
`define HECL_DEF_MP_HS 8'h57
`define HECL_DEF_HC_FSB 8'h50
`define HECL_DEF_HC_HSB 8'hae
`define HECL_DEF_HC_FSS 8'h50
`define HECL_DEF_HC_HSS 8'h64
`define HECL_DEF_PGOOD 8'h32

// SPI EEPROM commands.
`define HECL_CMD_READ 8'h03
`define HECL_CMD_WRITE 8'h02
`define HECL_CMD_WREN 8'h06

// Register byte offsets on the AHB-Lite slave.
`define HECL_A_CTRL 8'h00
`define HECL_A_STAT 8'h04
`define HECL_A_IDS 8'h08
`define HECL_A_DID 8'h0c
`define HECL_A_POWER 8'h10
`define HECL_A_WRITE 8'h14
`define HECL_A_STRING 8'h18

// Link timing: SPI half period of 80 ns at 200 MHz.
`define HECL_CLK_MHZ 200
`define HECL_SCK_HALF_NS 80
`define HECL_SCK_HALF_CYC ((`HECL_SCK_HALF_NS * `HECL_CLK_MHZ) / 1000)

`endif

/* logic/hecl_image_mem.v */
/*
 * Small byte memory holding the first bytes of the configuration image.
 * Assumes a single writer and reader on hclk; read data are registered.
 */
`timescale 1ns/100ps
`include "hecl_regs.vh"
module hecl_image_mem #(
    parameter AW = 5
) (
    input wire hclk, // Core clock.
    input wire we, // Write strobe.
    input wire [AW-1:0] waddr, // Write address.
    input wire [7:0] wdata, // Write byte.
    input wire [AW-1:0] raddr, // Read address.
    output reg [7:0] rdata // Registered read byte.
);
    reg [7:0] mem [0:(1<<AW)-1];

    // No reset on the array: contents are only trusted after a load.
    always @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* logic/hecl_spi_byte.v */
/*
 * SPI mode 0 byte shifter for the configuration EEPROM link.
 * Assumes miso already synchronised; sck is produced from hclk by a divider.
 */
`timescale 1ns/100ps
`include "hecl_regs.vh"
module hecl_spi_byte #(
    parameter HALF = `HECL_SCK_HALF_CYC
) (
    input wire hclk, // Core clock.
    input wire hresetn, // Asynchronous reset, active low.
    input wire start, // Pulse: shift one byte.
    input wire [7:0] tx, // Byte to send.
    input wire miso_s, // Synchronised serial input.
    output reg [7:0] rx_r, // Byte received.
    output reg done_r, // Pulse: byte finished.
    output reg sck_r, // Serial clock.
    output reg mosi_r // Serial output.
);
    reg [7:0] div_r;
    reg [7:0] sh_r;
    reg [3:0] bit_r;
    reg busy_r;
    wire tick = (div_r == HALF - 1);

    // Each tick toggles sck; sample on rising, shift on falling edge.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 8'h00;
            sh_r <= 8'h00;
            bit_r <= 4'h0;
            busy_r <= 1'b0;
            rx_r <= 8'h00;
            done_r <= 1'b0;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                sh_r <= tx;
                mosi_r <= tx[7];
                bit_r <= 4'h0;
                div_r <= 8'h00;
            end else if (busy_r) begin
                div_r <= tick ? 8'h00 : div_r + 8'h01;
                if (tick) begin
                    sck_r <= ~sck_r;
                    if (!sck_r) begin
                        rx_r <= {rx_r[6:0], miso_s};
                    end else begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        mosi_r <= sh_r[6];
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h7) begin
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule

/* verification/hecl_eeprom_model.sv */
/* SPI mode 0 EEPROM holding the image.
 * Assumes img is filled before a frame. */
`timescale 1ns/100ps
module hecl_eeprom_model (
    input wire spi_cs_n, // Select, active low.
    input wire spi_sck, // Serial clock.
    input wire spi_mosi, // Data from the loader.
    output logic spi_miso // Data to the loader.
);
    logic [7:0] img [0:31];
    logic [23:0] hdr_r;
    int bit_cnt;
    initial spi_miso = 1'b0;
    // A frame restarts the count.
    always @(negedge spi_cs_n) bit_cnt = 0;
    // Command and address arrive on rising edges.
    always @(posedge spi_sck) begin
        if (!spi_cs_n && bit_cnt < 24)
            hdr_r = {hdr_r[22:0], spi_mosi};
        bit_cnt = bit_cnt + 1;
    end
    // Data change on falls to settle before rises.
    always @(negedge spi_sck) begin
        if (!spi_cs_n && bit_cnt >= 24)
            spi_miso <= img[(hdr_r[4:0] + (bit_cnt - 24) / 8) % 32][7 - (bit_cnt - 24) % 8];
    end
    // Released, the line inverts so a late sample fails.
    always @(posedge spi_cs_n) spi_miso <= ~spi_miso;
endmodule

/* verification/hecl_checker.sv */
/* Checks on the loader's ports.
 * Assumes binding into the loader; hclk is the only clock. */
`timescale 1ns/100ps
module hecl_checker (
    input wire hclk, // Core clock.
    input wire hresetn, // Reset, active low.
    input wire hreadyout, // Slave ready.
    input wire hresp, // Response.
    input wire high_speed, // Upstream is high speed.
    input wire self_powered, // Self powered.
    input wire spi_cs_n, // EEPROM select.
    input wire spi_sck, // EEPROM clock.
    input wire spi_mosi, // EEPROM data out.
    input wire cfg_valid, // Image accepted.
    input wire [3:0] enabled_port_oc_filter_ms, // Enabled filter.
    input wire [3:0] disabled_port_oc_filter_ms, // Disabled filter.
    input wire [7:0] upstream_current_budget, // Maximum power.
    input wire [7:0] controller_current_draw, // Controller current.
    input wire [7:0] port_power_good_delay, // Power good delay.
    input wire write_protect // Writes refused.
);
    logic [3:0] idle_cnt;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Defaults are judged only after the link is quiet.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            idle_cnt <= 4'h0;
        else if (!spi_cs_n)
            idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf)
            idle_cnt <= idle_cnt + 4'h1;
    end
    sequence calm;
        !cfg_valid && idle_cnt[3] && $stable({high_speed, self_powered});
    endsequence
    sequence sck_high_half;
        spi_sck [*8] ##9 $fell(spi_sck);
    endsequence
    chk_ready_always: assert property (hreadyout) else $error("ready dropped");
    chk_resp_okay: assert property (!hresp) else $error("error response");
    chk_budget_default: assert property (calm |-> upstream_current_budget ==
        (high_speed ? 8'h57 : 8'h28)) else $error("budget default wrong");
    chk_draw_default: assert property (calm |-> controller_current_draw ==
        (self_powered ? (high_speed ? 8'h64 : 8'h50) : (high_speed ? 8'hae : 8'h50)))
        else $error("controller current default wrong");
    chk_misc_default: assert property (calm |-> {enabled_port_oc_filter_ms,
        disabled_port_oc_filter_ms, port_power_good_delay, write_protect} == 17'h11064)
        else $error("filter or delay default wrong");
    chk_idle_sck_low: assert property (spi_cs_n |-> !spi_sck) else $error("clock high idle");
    chk_sck_half: assert property ($rose(spi_sck) |-> sck_high_half)
        else $error("clock half period wrong");
    chk_mosi_hold: assert property (!spi_cs_n && spi_sck && $past(spi_sck) |-> $stable(spi_mosi))
        else $error("data moved while clock high");
endmodule

/* verification/tb_top.sv */
/* Bench of the configuration loader.
 * Assumes the loader, EEPROM model and checker are compiled. */
`timescale 1ns/100ps
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic high_speed = 1'b0, self_powered = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd;
    logic [7:0] def_draw [4] = '{8'h50, 8'h50, 8'hae, 8'h64};
    wire [31:0] hrdata;
    wire [15:0] vendor_id, product_id;
    wire [7:0] device_id_hi, upstream_current_budget, controller_current_draw;
    wire [7:0] port_power_good_delay;
    wire [3:0] enabled_port_oc_filter_ms, disabled_port_oc_filter_ms;
    wire hreadyout, hresp, spi_miso, spi_cs_n, spi_sck, spi_mosi;
    wire cfg_valid, write_protect, strings_enabled;
    int bad_count = 0, n_compared = 0, cyc = 0;
    hecl_loader dut (.*, .hready(hreadyout));
    hecl_eeprom_model eep (.*);
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    // Seven loads of about 7000 cycles fit under this.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            end_of_test;
        end
    end
    task automatic chk(input string name, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One word transfer; each phase waits for ready.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // Image byte i is 0x10 + i unless set.
    task automatic load(input logic [7:0] sig, b19, b20);
        for (int i = 0; i < 32; i++)
            eep.img[i] = 8'h10 + i[7:0];
        eep.img[0] = sig;
        eep.img[10] = 8'h00;
        eep.img[11] = 8'h00;
        eep.img[19] = b19;
        eep.img[20] = b20;
        {high_speed, self_powered} <= 2'b00;
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        while (spi_cs_n === 1'b1) @(posedge hclk);
        while (spi_cs_n === 1'b0) @(posedge hclk);
        repeat (4) @(posedge hclk);
    endtask
    // All four speed and power states, live.
    task automatic sweep(input logic ld);
        for (int m = 0; m < 4; m++) begin
            {high_speed, self_powered} <= m[1:0];
            repeat (2) @(posedge hclk);
            chk("budget", upstream_current_budget, ld ? 8'h18 + m[1] : (m[1] ? 8'h57 : 8'h28));
            chk("draw", controller_current_draw, ld ? 8'h1c + m[1] + 2 * m[0] : def_draw[m]);
        end
    endtask
    task automatic t_defaults;
        load(8'hff, 8'h42, 8'h05);
        chk("cfg_valid", cfg_valid, 0);
        sweep(0);
        ahb(0, 8'h10, 0);
        chk("power reg", rd, 32'h3264_5788);
        chk("wp", write_protect, 0);
    endtask
    task automatic t_image;
        load(8'hd4, 8'h42, 8'h20);
        chk("cfg_valid", cfg_valid, 1);
        chk("ids", {product_id, vendor_id}, 32'h1413_1211);
        chk("did", device_id_hi, 8'h16);
        chk("oc", {enabled_port_oc_filter_ms, disabled_port_oc_filter_ms}, 8'h17);
        chk("pgood", port_power_good_delay, 8'h20);
        sweep(1);
        ahb(0, 8'h08, 0);
        chk("id reg", rd, 32'h1413_1211);
        ahb(0, 8'h10, 0);
        chk("power reg", rd, 32'h201f_1917);
        ahb(0, 8'h18, 0);
        chk("langs", rd, 32'h20);
        ahb(1, 8'h00, 32'h4);
        repeat (2) @(posedge hclk);
        ahb(0, 8'h04, 0);
        chk("refused", rd[7], 1);
        ahb(1, 8'h40, 32'hffff_ffff);
        ahb(0, 8'h40, 0);
        chk("unmapped", rd, 0);
    endtask
    // Key and language limits, wrong signature.
    task automatic t_bounds;
        logic [7:0] b19 [4] = '{8'h42, 8'h41, 8'h00, 8'h42};
        logic [7:0] b20 [4] = '{8'h20, 8'h1f, 8'h00, 8'h01};
        logic [1:0] ex [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
        for (int k = 0; k < 4; k++) begin
            load(8'hd4, b19[k], b20[k]);
            chk("wp strings", {write_protect, strings_enabled}, ex[k]);
        end
        load(8'hd2, 8'h42, 8'h01);
        chk("foreign sig", {cfg_valid, write_protect, port_power_good_delay}, 10'h032);
    endtask
    initial begin
        t_defaults;
        t_image;
        t_bounds;
        end_of_test;
    end
endmodule
bind hecl_loader hecl_checker u_chk (.*);
